// ---- design/ber_check_consts.vh ----
// constants for the lane status and bit-error-rate check block
// assumes 15-bit register addresses and 8-bit register data on the serial port
`ifndef BER_CHECK_CONSTS_VH
`define BER_CHECK_CONSTS_VH

// register addresses
`define A_LANE_FULL   15'h030c
`define A_LANE_EMPTY  15'h030d
`define A_SYNC_LEN    15'h0312
`define A_SETUP_CFG   15'h0314
`define A_BER_EN      15'h0315
`define A_BER_CTRL    15'h0316
`define A_THR_LO      15'h0317
`define A_THR_MID     15'h0318
`define A_THR_HI      15'h0319
`define A_CNT_LO      15'h031a
`define A_CNT_MID     15'h031b
`define A_CNT_HI      15'h031c
`define A_PASS        15'h031d

// reset values
`define RST_ZERO      8'h00
`define RST_PASS      8'hff
`define RST_SYNC_LEN  8'h00

// field positions
`define F_SYNC_DUR    5:4
`define F_CTL_CLEAR   0
`define F_CTL_RUN     1
`define F_CTL_PAT     3:2
`define F_CTL_SEL     6:4
`define F_CTL_RW      6:0
`define F_BYTE0       7:0
`define F_BYTE1       15:8
`define F_BYTE2       23:16

// pulse length codes
`define DUR_HALF      2'h0
`define DUR_ONE       2'h1

// pattern codes
`define PAT_P7        2'h0
`define PAT_P15       2'h1
`define PAT_P31       2'h2

// serial frame: one rw bit, 15 address bits, 8 data bits
`define SPI_HDR_BITS  5'h10
`define SPI_ALL_BITS  5'h18
`define SPI_CNT_W     5

`endif

// ---- design/prbs_lane_check.v ----
// one lane of the pseudo-random bit checker with a saturating error count
// assumes step is a one-cycle strobe per received bit, bit_in valid with it
`include "ber_check_consts.vh"

module prbs_lane_check #(
  parameter CW = 24
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          clear,
  input  wire          run,
  input  wire          step,
  input  wire          bit_in,
  input  wire [1:0]    pattern,
  output reg  [CW-1:0] err_cnt_ff
);

  reg  [30:0] hist_ff;
  reg  [4:0]  fill_ff;
  reg  [1:0]  pat_ff;
  reg         pred;
  reg         known;
  reg  [4:0]  need;
  wire        locked = (fill_ff >= need);
  wire        miss   = known & locked & (bit_in != pred);
  wire [CW-1:0] cnt_max = {CW{1'b1}};

  ////////////////////////////////////////////////////////////////////////
  // predicted bit from the last received bits (self-synchronising)
  always @* begin
    pred  = 1'b0;
    known = 1'b1;
    need  = 5'd31;
    case (pattern)
      `PAT_P7: begin
        pred = hist_ff[6] ^ hist_ff[5];
        need = 5'd7;
      end
      `PAT_P15: begin
        pred = hist_ff[14] ^ hist_ff[13];
        need = 5'd15;
      end
      `PAT_P31: begin
        pred = hist_ff[30] ^ hist_ff[27];
      end
      default: known = 1'b0;                           // reserved code checks nothing
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // history, lock fill and error count; a pattern change forces relock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_ff    <= 31'h0;
      fill_ff    <= 5'h0;
      pat_ff     <= 2'h0;
      err_cnt_ff <= {CW{1'b0}};
    end else if (clear) begin
      hist_ff    <= 31'h0;
      fill_ff    <= 5'h0;
      err_cnt_ff <= {CW{1'b0}};
    end else if (pattern != pat_ff) begin
      pat_ff  <= pattern;
      fill_ff <= 5'h0;
    end else if (run && step) begin
      hist_ff <= {hist_ff[29:0], bit_in};
      if (!locked)
        fill_ff <= fill_ff + 5'h1;
      if (miss && err_cnt_ff != cnt_max)
        err_cnt_ff <= err_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ---- design/serdes_lane_prbs_checker.v ----
// lane buffer flags, sync error pulse and per-lane bit-error-rate checker
// assumes all pins are asynchronous to MCLK; PCLK runs well below MCLK / 4
// and lane data changes away from the PCLK rising edge
`include "ber_check_consts.vh"

module serdes_lane_prbs_checker #(
  parameter LANES = 8,
  parameter CW    = 24
) (
  // clock and reset
  input  wire             MCLK,
  input  wire             NRST,
  // serial register port
  input  wire             SCLK,
  input  wire             CS_N,
  input  wire             SDI,
  output reg              SDO,
  output reg              SDO_OE,
  // lane side, timed by the parallel clock
  input  wire             PCLK,
  input  wire [LANES-1:0] LANE_BIT,
  input  wire             DISP_ERR,
  input  wire             TABLE_ERR,
  input  wire             CTRL_ERR,
  input  wire             MF_END,
  // receive buffer state
  input  wire [LANES-1:0] BUF_EMPTY,
  input  wire [LANES-1:0] BUF_FULL,
  // sync request pins, active low
  output reg              SYNC_REQ_OUT0_N,
  output reg              SYNC_REQ_OUT1_N
);

  localparam AW = 4 + 3 * LANES;

  // serial port states
  localparam [3:0] SP_HDR  = 4'b0001;
  localparam [3:0] SP_WR   = 4'b0010;
  localparam [3:0] SP_RD   = 4'b0100;
  localparam [3:0] SP_DONE = 4'b1000;

  // sync pulse states
  localparam [1:0] SY_IDLE = 2'b01;
  localparam [1:0] SY_LOW  = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every pin input; only sync_ff is read
  reg  [AW-1:0] meta_ff;
  reg  [AW-1:0] sync_ff;
  reg           sclk_d_ff;
  reg           pclk_d_ff;

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      meta_ff   <= {AW{1'b0}};
      sync_ff   <= {AW{1'b0}};
      sclk_d_ff <= 1'b0;
      pclk_d_ff <= 1'b0;
    end else begin
      meta_ff   <= {SCLK, CS_N, SDI, PCLK, LANE_BIT, BUF_EMPTY, BUF_FULL};
      sync_ff   <= meta_ff;
      sclk_d_ff <= sync_ff[AW-1];
      pclk_d_ff <= sync_ff[AW-4];
    end
  end

  wire             sclk_s  = sync_ff[AW-1];
  wire             cs_n_s  = sync_ff[AW-2];
  wire             sdi_s   = sync_ff[AW-3];
  wire             pclk_s  = sync_ff[AW-4];
  wire [LANES-1:0] lane_s  = sync_ff[3*LANES-1:2*LANES];
  wire [LANES-1:0] empty_s = sync_ff[2*LANES-1:LANES];
  wire [LANES-1:0] full_s  = sync_ff[LANES-1:0];
  wire             sclk_rise = sclk_s & ~sclk_d_ff;
  wire             sclk_fall = ~sclk_s & sclk_d_ff;
  wire             pclk_rise = pclk_s & ~pclk_d_ff;
  wire             pclk_fall = ~pclk_s & pclk_d_ff;

  // error strobes travel on their own pair of flops
  reg  [3:0] emeta_ff;
  reg  [3:0] esync_ff;

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      emeta_ff <= 4'h0;
      esync_ff <= 4'h0;
    end else begin
      emeta_ff <= {DISP_ERR, TABLE_ERR, CTRL_ERR, MF_END};
      esync_ff <= emeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer state flags, refreshed every cycle
  reg [LANES-1:0] empty_ff;
  reg [LANES-1:0] full_ff;

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      empty_ff <= {LANES{1'b0}};
      full_ff  <= {LANES{1'b0}};
    end else begin
      empty_ff <= empty_s;
      full_ff  <= full_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers
  reg [7:0]    sync_len_ff;
  reg [7:0]    setup_ff;
  reg [7:0]    ber_en_ff;
  reg [6:0]    ctrl_ff;
  reg [CW-1:0] limit_ff;
  reg          wr_go;
  reg [14:0]   addr_ff;
  reg [7:0]    wdata;

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sync_len_ff <= `RST_SYNC_LEN;
      setup_ff    <= `RST_ZERO;
      ber_en_ff   <= `RST_ZERO;
      ctrl_ff     <= 7'h00;
      limit_ff    <= {CW{1'b0}};
    end else if (wr_go) begin
      if (addr_ff == `A_SYNC_LEN)
        sync_len_ff <= wdata;
      else if (addr_ff == `A_SETUP_CFG)
        setup_ff <= wdata;
      else if (addr_ff == `A_BER_EN)
        ber_en_ff <= wdata;
      else if (addr_ff == `A_BER_CTRL)
        ctrl_ff <= wdata[`F_CTL_RW];                   // bit 7 reserved, not kept
      else if (addr_ff == `A_THR_LO)
        limit_ff[`F_BYTE0] <= wdata;
      else if (addr_ff == `A_THR_MID)
        limit_ff[`F_BYTE1] <= wdata;
      else if (addr_ff == `A_THR_HI)
        limit_ff[`F_BYTE2] <= wdata;
    end
  end

  wire       ber_clear = ctrl_ff[`F_CTL_CLEAR];
  wire       ber_run   = ctrl_ff[`F_CTL_RUN];
  wire [1:0] pattern   = ctrl_ff[`F_CTL_PAT];
  wire [2:0] cnt_sel   = ctrl_ff[`F_CTL_SEL];

  ////////////////////////////////////////////////////////////////////////
  // one checker per lane; pass flags follow the counts
  wire [LANES*CW-1:0] tally;
  reg  [LANES-1:0]    pass_ff;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      prbs_lane_check #(
        .CW (CW)
      ) u_chk (
        .clk        (MCLK),
        .rst_n      (NRST),
        .clear      (ber_clear),
        .run        (ber_run & ber_en_ff[g]),
        .step       (pclk_rise),
        .bit_in     (lane_s[g]),
        .pattern    (pattern),
        .err_cnt_ff (tally[g*CW +: CW])
      );

      // a disabled lane keeps reporting pass
      always @(posedge MCLK or negedge NRST) begin
        if (!NRST)
          pass_ff[g] <= 1'b1;
        else if (!ber_en_ff[g])
          pass_ff[g] <= 1'b1;
        else
          pass_ff[g] <= (tally[g*CW +: CW] < limit_ff);
      end
    end
  endgenerate

  wire [CW-1:0] sel_tally = tally[cnt_sel*CW +: CW];

  ////////////////////////////////////////////////////////////////////////
  // read data mux; unmapped addresses read zero
  reg [7:0] rdata;

  always @* begin
    rdata = 8'h00;
    if (addr_ff == `A_LANE_FULL)
      rdata = full_ff;
    else if (addr_ff == `A_LANE_EMPTY)
      rdata = empty_ff;
    else if (addr_ff == `A_SYNC_LEN)
      rdata = sync_len_ff;
    else if (addr_ff == `A_SETUP_CFG)
      rdata = setup_ff;
    else if (addr_ff == `A_BER_EN)
      rdata = ber_en_ff;
    else if (addr_ff == `A_BER_CTRL)
      rdata = {1'b0, ctrl_ff};
    else if (addr_ff == `A_THR_LO)
      rdata = limit_ff[`F_BYTE0];
    else if (addr_ff == `A_THR_MID)
      rdata = limit_ff[`F_BYTE1];
    else if (addr_ff == `A_THR_HI)
      rdata = limit_ff[`F_BYTE2];
    else if (addr_ff == `A_CNT_LO)
      rdata = sel_tally[`F_BYTE0];
    else if (addr_ff == `A_CNT_MID)
      rdata = sel_tally[`F_BYTE1];
    else if (addr_ff == `A_CNT_HI)
      rdata = sel_tally[`F_BYTE2];
    else if (addr_ff == `A_PASS)
      rdata = pass_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // serial port: rw bit (1 = read), 15 address bits, 8 data bits, msb first;
  // input sampled on SCLK rise, output changed on SCLK fall
  reg [3:0]            sp_state_ff;
  reg [`SPI_CNT_W-1:0] bit_cnt_ff;
  reg [15:0]           shin_ff;
  reg [7:0]            shout_ff;
  wire [`SPI_CNT_W-1:0] bit_nxt = bit_cnt_ff + 5'h1;

  always @* begin
    wr_go = 1'b0;
    wdata = {shin_ff[6:0], sdi_s};
    if (sp_state_ff == SP_WR && sclk_rise && !cs_n_s && bit_nxt == `SPI_ALL_BITS)
      wr_go = 1'b1;
  end

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sp_state_ff <= SP_HDR;
      bit_cnt_ff  <= 5'h0;
      shin_ff     <= 16'h0000;
      shout_ff    <= 8'h00;
      addr_ff     <= 15'h0000;
      SDO         <= 1'b0;
      SDO_OE      <= 1'b0;
    end else if (cs_n_s) begin
      // chip select high ends any frame, complete or not
      sp_state_ff <= SP_HDR;
      bit_cnt_ff  <= 5'h0;
      SDO         <= 1'b0;
      SDO_OE      <= 1'b0;
    end else begin
      case (sp_state_ff)
        SP_HDR: begin
          if (sclk_rise) begin
            shin_ff    <= {shin_ff[14:0], sdi_s};
            bit_cnt_ff <= bit_nxt;
            if (bit_nxt == `SPI_HDR_BITS) begin
              addr_ff <= {shin_ff[13:0], sdi_s};
              if (shin_ff[14])
                sp_state_ff <= SP_RD;
              else
                sp_state_ff <= SP_WR;
            end
          end
        end
        SP_WR: begin
          if (sclk_rise) begin
            shin_ff    <= {shin_ff[14:0], sdi_s};
            bit_cnt_ff <= bit_nxt;
            if (bit_nxt == `SPI_ALL_BITS)
              sp_state_ff <= SP_DONE;
          end
        end
        SP_RD: begin
          // first falling edge after the header presents bit 7
          if (bit_cnt_ff == `SPI_HDR_BITS && !SDO_OE) begin
            shout_ff <= rdata;
            SDO_OE   <= 1'b1;
          end else if (sclk_fall) begin
            SDO      <= shout_ff[7];
            shout_ff <= {shout_ff[6:0], 1'b0};
          end else if (sclk_rise) begin
            bit_cnt_ff <= bit_nxt;
            if (bit_nxt == `SPI_ALL_BITS)
              sp_state_ff <= SP_DONE;
          end
        end
        SP_DONE: begin
          // extra clocks are ignored until chip select rises
          SDO_OE <= SDO_OE;
        end
        default: sp_state_ff <= SP_HDR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // multiframe error collection, sampled at each PCLK rise
  reg  mf_err_ff;
  wire err_now = |esync_ff[3:1];
  wire mf_end  = esync_ff[0];

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST)
      mf_err_ff <= 1'b0;
    else if (pclk_rise) begin
      if (mf_end)
        mf_err_ff <= 1'b0;
      else if (err_now)
        mf_err_ff <= 1'b1;
    end
  end

  wire sync_fire = pclk_rise & mf_end & (mf_err_ff | err_now);

  ////////////////////////////////////////////////////////////////////////
  // sync low pulse; half cycle ends at the PCLK fall, others count rises.
  // a sync_fire during a pulse is dropped: the far end is already resyncing
  reg  [1:0] sy_state_ff;
  reg  [1:0] edges_ff;
  wire [1:0] dur = sync_len_ff[`F_SYNC_DUR];
  wire [1:0] nxt_edges = edges_ff + 2'h1;
  reg        pulse_end;

  always @* begin
    pulse_end = 1'b0;
    if (dur == `DUR_HALF)
      pulse_end = pclk_fall;
    else if (dur == `DUR_ONE)
      pulse_end = pclk_rise;
    else
      pulse_end = pclk_rise & (edges_ff == 2'h1);      // codes 2 and 3: two cycles
  end

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sy_state_ff     <= SY_IDLE;
      edges_ff        <= 2'h0;
      SYNC_REQ_OUT0_N <= 1'b1;
      SYNC_REQ_OUT1_N <= 1'b1;
    end else begin
      case (sy_state_ff)
        SY_IDLE: begin
          edges_ff <= 2'h0;
          if (sync_fire) begin
            sy_state_ff     <= SY_LOW;
            SYNC_REQ_OUT0_N <= 1'b0;
            SYNC_REQ_OUT1_N <= 1'b0;
          end
        end
        SY_LOW: begin
          if (pulse_end) begin
            sy_state_ff     <= SY_IDLE;
            SYNC_REQ_OUT0_N <= 1'b1;
            SYNC_REQ_OUT1_N <= 1'b1;
          end else if (pclk_rise) begin
            edges_ff <= nxt_edges;
          end
        end
        default: sy_state_ff <= SY_IDLE;
      endcase
    end
  end

endmodule

// ---- verif/prbs_lane_source.sv ----
// far-side model: a lane transmitter sending one pseudo-random stream on all lanes
// assumes the bench raises flips and link errors as levels for one beat
module prbs_lane_source (
  // requests from the bench
  input  wire logic [1:0] pattern,
  input  wire logic [7:0] flip_mask,
  input  wire logic [1:0] err_kind,
  // lane side of the receiver
  output logic            pclk,
  output logic [7:0]      lane_bit,
  output logic            disp_err,
  output logic            table_err,
  output logic            ctrl_err,
  output logic            mf_end
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [30:0] hist_ff;
  logic [1:0]  beat_ff;
  logic        nb;
  // free-running beat clock; the 1.5 ns offset keeps every edge clear of MCLK edges
  initial begin
    pclk = 1'b0;
    hist_ff = 31'h0000_0001;
    beat_ff = 2'h0;
    lane_bit = 8'h00;
    {disp_err, table_err, ctrl_err, mf_end} = 4'h0;
  end
  initial begin
    #1.5;
    forever #62.5 pclk = ~pclk;
  end
  // all lines move at the fall, half a beat clear of the sampling rise
  always @(negedge pclk) begin
    case (pattern)
      2'h0: nb = hist_ff[6] ^ hist_ff[5];
      2'h1: nb = hist_ff[14] ^ hist_ff[13];
      default: nb = hist_ff[30] ^ hist_ff[27];
    endcase
    hist_ff <= {hist_ff[29:0], nb};
    lane_bit <= {8{nb}} ^ flip_mask;
    disp_err <= err_kind == 2'h1;
    table_err <= err_kind == 2'h2;
    ctrl_err <= err_kind == 2'h3;
    beat_ff <= beat_ff + 2'h1;
    mf_end <= beat_ff == 2'h3;
  end
endmodule

// ---- verif/serdes_lane_prbs_checker_props.sv ----
// pin-level checks for the lane status and bit-error check block
// assumes SCLK phases of 6 MCLK and a PCLK near 125 ns from the bench
module serdes_lane_prbs_checker_props (
  // clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // serial port
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDO,
  input wire logic SDO_OE,
  // link side
  input wire logic DISP_ERR,
  input wire logic TABLE_ERR,
  input wire logic CTRL_ERR,
  input wire logic MF_END,
  input wire logic SYNC_REQ_OUT0_N,
  input wire logic SYNC_REQ_OUT1_N
);
  logic [5:0] low_ff;
  logic [3:0] mf_age_ff;
  logic       err_ff;
  logic [4:0] rise_ff;
  logic       sclk_ff;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
////////////////////////////////////////////////////////////
  // low and multiframe age counts saturate so a stuck line never wraps back into range
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      low_ff    <= 6'h0;
      mf_age_ff <= 4'hf;
      err_ff    <= 1'b0;
      rise_ff   <= 5'h0;
      sclk_ff   <= 1'b0;
    end else begin
      low_ff    <= SYNC_REQ_OUT0_N ? 6'h0 : low_ff + {5'h0, low_ff != 6'h3f};
      mf_age_ff <= MF_END ? 4'h0 : mf_age_ff + {3'h0, mf_age_ff != 4'hf};
      err_ff    <= DISP_ERR | TABLE_ERR | CTRL_ERR
                   | (err_ff & ~(low_ff == 6'h0 & ~SYNC_REQ_OUT0_N));
      rise_ff   <= CS_N ? 5'h0 : rise_ff + {4'h0, SCLK & ~sclk_ff};
      sclk_ff   <= SCLK;
    end
  end
////////////////////////////////////////////////////////////
  // sync pulse shape and cause
  a_sync_pins_equal: assert property (SYNC_REQ_OUT0_N == SYNC_REQ_OUT1_N)
    else $error("sync outputs differ");
  a_sync_len_max: assert property (low_ff <= 6'h1b)
    else $error("sync low longer than two beats");
  a_sync_len_min: assert property ($fell(SYNC_REQ_OUT0_N) |-> !SYNC_REQ_OUT0_N [*5])
    else $error("sync low shorter than half a beat");
  a_sync_after_mfend: assert property ($fell(SYNC_REQ_OUT0_N) |-> mf_age_ff <= 4'h8)
    else $error("sync fell away from a multiframe end");
  a_sync_needs_err: assert property ($fell(SYNC_REQ_OUT0_N) |-> err_ff)
    else $error("sync fell with no link error seen");
  a_reset_idle: assert property ($rose(NRST) |-> SYNC_REQ_OUT0_N && !SDO_OE)
    else $error("outputs not idle after reset");
  // read data phase of the serial port
  a_oe_at_sixteen: assert property ($rose(SDO_OE) |-> rise_ff == 5'h10 && !CS_N)
    else $error("read drive began off the sixteenth clock");
  a_oe_drops: assert property ($rose(CS_N) |-> ##[1:6] !SDO_OE)
    else $error("read drive held after deselect");
  a_sdo_on_low: assert property (SDO_OE && $changed(SDO) |-> !SCLK)
    else $error("read data moved while serial clock high");
endmodule

bind serdes_lane_prbs_checker serdes_lane_prbs_checker_props props_i (
  .MCLK(MCLK), .NRST(NRST), .SCLK(SCLK), .CS_N(CS_N), .SDO(SDO), .SDO_OE(SDO_OE),
  .DISP_ERR(DISP_ERR), .TABLE_ERR(TABLE_ERR), .CTRL_ERR(CTRL_ERR), .MF_END(MF_END),
  .SYNC_REQ_OUT0_N(SYNC_REQ_OUT0_N), .SYNC_REQ_OUT1_N(SYNC_REQ_OUT1_N));

// ---- verif/serdes_lane_prbs_checker_tb.sv ----
// self-checking bench for the lane status and bit-error check block
// assumes the design header is on the include path
`include "ber_check_consts.vh"
module serdes_lane_prbs_checker_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       MCLK, NRST, SCLK, CS_N, SDI;
  logic [7:0] BUF_EMPTY, BUF_FULL, flip;
  logic [1:0] pat, ekind;
  wire        SDO, SDO_OE, PCLK, DISP_ERR, TABLE_ERR, CTRL_ERR, MF_END;
  wire        SYNC_REQ_OUT0_N, SYNC_REQ_OUT1_N;
  wire  [7:0] LANE_BIT;
  int         err_count, n_compared, i;
  // rows: {rw, address, write data, expected read}
  localparam logic [31:0] ROWS [29] = '{
    32'h830d_0000, 32'h8312_0000, 32'h8314_0000, 32'h8315_0000, 32'h8316_0000,
    32'h8317_0000, 32'h8318_0000, 32'h8319_0000, 32'h831a_0000, 32'h831b_0000,
    32'h831c_0000, 32'h831d_00ff, 32'h0314_0100, 32'h8314_0001, 32'h0316_ff00,
    32'h8316_007f, 32'h031d_0000, 32'h831d_00ff, 32'h031a_5500, 32'h831a_0000,
    32'h0317_1200, 32'h0318_3400, 32'h0319_5600, 32'h8317_0012, 32'h8318_0034,
    32'h8319_0056, 32'h0318_0000, 32'h0319_0000, 32'h8320_0000};
  serdes_lane_prbs_checker serdes_lane_prbs_checker_i (
    .MCLK(MCLK), .NRST(NRST), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI), .SDO(SDO),
    .SDO_OE(SDO_OE), .PCLK(PCLK), .LANE_BIT(LANE_BIT), .DISP_ERR(DISP_ERR),
    .TABLE_ERR(TABLE_ERR), .CTRL_ERR(CTRL_ERR), .MF_END(MF_END),
    .BUF_EMPTY(BUF_EMPTY), .BUF_FULL(BUF_FULL),
    .SYNC_REQ_OUT0_N(SYNC_REQ_OUT0_N), .SYNC_REQ_OUT1_N(SYNC_REQ_OUT1_N));
  prbs_lane_source prbs_lane_source_i (
    .pattern(pat), .flip_mask(flip), .err_kind(ekind), .pclk(PCLK),
    .lane_bit(LANE_BIT), .disp_err(DISP_ERR), .table_err(TABLE_ERR),
    .ctrl_err(CTRL_ERR), .mf_end(MF_END));
  always #5 MCLK = ~MCLK;
  // a hang anywhere ends the run as a mismatch
  initial begin
    repeat (90000) @(negedge MCLK);
    err_count++;
    complete_run;
  end
////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // pulse widths come from sampling at 10 ns, so a 15 ns slack is allowed
  task automatic chk_ns(input string nm, input int exp, input int got);
    n_compared++;
    if (got > exp + 15 || got < exp - 15) begin
      err_count++;
      $display("BAD %s exp %0d got %0d", nm, exp, got);
    end
  endtask
  // one 24-bit frame; phases of 6 MCLK so the sync stage sees every edge
  task automatic xfer(input logic [15:0] hdr, input logic [7:0] wd, output logic [7:0] rv);
    logic [23:0] f;
    f = {hdr, wd};
    rv = 8'h00;
    CS_N = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      SDI = f[b];
      repeat (6) @(negedge MCLK);
      if (b < 8) rv[b] = SDO;
      SCLK = 1'b1;
      repeat (6) @(negedge MCLK);
      SCLK = 1'b0;
    end
    CS_N = 1'b1;
    repeat (6) @(negedge MCLK);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({1'b0, a}, d, x);
  endtask
  task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] x;
    xfer({1'b1, a}, 8'h00, x);
    chk8($sformatf("reg %h", a), exp, x);
  endtask
  task automatic beats(input int n);
    repeat (n) @(posedge PCLK);
    @(negedge MCLK);
  endtask
  // flips and errors last exactly one transmitted beat
  task automatic inject(input logic [7:0] m, input logic [1:0] k);
    flip = m;
    ekind = k;
    @(negedge PCLK);
    @(posedge PCLK);
    @(negedge MCLK);
    flip = 8'h00;
    ekind = 2'h0;
  endtask
////////////////////////////////////////////////////////////
  task automatic sync_case(input logic [1:0] len);
    int k, n;
    wr(`A_SYNC_LEN, {2'h0, len, 4'h0});
    inject(8'h00, 2'(len % 3 + 1));
    for (k = 0; k < 200 && SYNC_REQ_OUT0_N; k++) @(negedge MCLK);
    if (k == 200) begin
      err_count++;
      complete_run;
    end
    for (n = 0; n < 60 && !SYNC_REQ_OUT0_N; n++) @(negedge MCLK);
    chk_ns("sync low", len == 0 ? 63 : len == 1 ? 125 : 250, n * 10);
    n = 0;
    for (k = 0; k < 150; k++) begin
      @(negedge MCLK);
      n += (SYNC_REQ_OUT0_N !== 1'b1);
    end
    chk8("quiet sync", 8'h00, n[7:0]);
  endtask
  task automatic prbs_case(input int p);
    logic [1:0] pc;
    logic [2:0] fl;
    logic [7:0] cb;
    pc = p[1:0];
    fl = {pc, 1'b1};
    cb = {1'b0, fl, pc, 2'h0};
    pat = pc;
    beats(40);
    wr(`A_BER_CTRL, cb | 8'h01);
    wr(`A_BER_EN, ~(8'h01 << (fl + 3'h1)));
    wr(`A_THR_LO, 8'h03);
    wr(`A_BER_CTRL, cb | 8'h02);
    beats(40);
    inject(8'h03 << fl, 2'h0);
    // the long taps see the flipped bit up to 31 beats later
    beats(32);
    rdchk(`A_CNT_LO, 8'h03);
    rdchk(`A_CNT_MID, 8'h00);
    rdchk(`A_PASS, ~(8'h01 << fl));
    wr(`A_BER_CTRL, {1'b0, fl + 3'h1, pc, 2'h2});
    rdchk(`A_CNT_LO, 8'h00);
    wr(`A_THR_LO, 8'h04);
    rdchk(`A_PASS, 8'hff);
    wr(`A_BER_CTRL, cb);
    inject(8'h03 << fl, 2'h0);
    beats(12);
    rdchk(`A_CNT_LO, 8'h03);
    wr(`A_BER_CTRL, cb | 8'h01);
    rdchk(`A_CNT_LO, 8'h00);
  endtask
////////////////////////////////////////////////////////////
  initial begin
    MCLK = 1'b0;
    NRST = 1'b0;
    {SCLK, SDI} = 2'h0;
    CS_N = 1'b1;
    {BUF_EMPTY, BUF_FULL, flip} = 24'h00_0000;
    {pat, ekind} = 4'h0;
    err_count = 0;
    n_compared = 0;
    repeat (10) @(negedge MCLK);
    NRST = 1'b1;
    repeat (3) @(negedge MCLK);
    for (i = 0; i < 29; i++) begin
      if (ROWS[i][31])
        rdchk(ROWS[i][30:16], ROWS[i][7:0]);
      else
        wr(ROWS[i][30:16], ROWS[i][15:8]);
    end
    BUF_EMPTY = 8'ha5;
    BUF_FULL = 8'h3c;
    rdchk(`A_LANE_EMPTY, 8'ha5);
    rdchk(`A_LANE_FULL, 8'h3c);
    for (i = 0; i < 4; i++) sync_case(i[1:0]);
    for (i = 0; i < 3; i++) prbs_case(i);
    // a second reset in mid-run must restore the table values
    wr(`A_BER_EN, 8'h5a);
    NRST = 1'b0;
    repeat (3) @(negedge MCLK);
    NRST = 1'b1;
    repeat (3) @(negedge MCLK);
    rdchk(`A_BER_EN, 8'h00);
    rdchk(`A_PASS, 8'hff);
    rdchk(`A_SYNC_LEN, 8'h00);
    complete_run;
  end
endmodule
